// ---- hdl/fpx_exception_unit.sv ----
// top: vector fp exception unit with axi4-lite register access
module fpx_exception_unit
   import fpx_pkg::*;
#(
   parameter int LANES = 4
) (
   // clock and reset
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_RESET,
   // axi4-lite write
   input  wire logic        I_AWVALID,
   input  wire logic [7:0]  I_AWADDR,
   output logic             O_AWREADY,
   input  wire logic        I_WVALID,
   input  wire logic [31:0] I_WDATA,
   input  wire logic [3:0]  I_WSTRB,
   output logic             O_WREADY,
   output logic             O_BVALID,
   output logic [1:0]       O_BRESP,
   input  wire logic        I_BREADY,
   // axi4-lite read
   input  wire logic        I_ARVALID,
   input  wire logic [7:0]  I_ARADDR,
   output logic             O_ARREADY,
   output logic             O_RVALID,
   output logic [31:0]      O_RDATA,
   output logic [1:0]       O_RRESP,
   input  wire logic        I_RREADY,
   // post-computation conditions from the datapath
   input  wire logic [2:0]  I_POST_FLAGS,
   // fault outputs
   output logic             O_SIMD_FP_FAULT,
   output logic             O_BAD_OPCODE_FAULT
);
   // ===================================================================
   // state
   typedef struct packed {
      logic        aw_got;
      logic [7:0]  awaddr;
      logic        w_got;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [31:0] csr;
      logic        os_en;
      logic [31:0] op_a;
      logic [31:0] op_b;
      logic [7:0]  cmd;
      logic [31:0] result;
      logic [2:0]  cond;
      logic [1:0]  fault;
      logic        vec_fault;
      logic        opc_fault;
      logic        aw_rdy;
      logic        w_rdy;
      logic        ar_rdy;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // ===================================================================
   // element checkers
   logic [LANES-1:0] lane_inv;
   logic [31:0]      lane_res [LANES];
   logic [2:0]       lane_cond [LANES];
   logic [3:0]       op_code;
   logic             cmd_wr;
   logic [7:0]       cmd_cur;

   // executing command still sits in the write slot
   assign cmd_wr  = st_r.aw_got && st_r.w_got && !st_r.bvalid && st_r.awaddr == ADDR_CMD;
   assign cmd_cur = cmd_wr ? st_r.wdata[7:0] : st_r.cmd;
   assign op_code = cmd_cur[3:0];

   for (genvar g = 0; g < LANES; g++) begin : g_lane
      fpx_lane_if lk ();
      assign lk.a    = st_r.op_a + 32'(g);
      assign lk.b    = st_r.op_b;
      assign lk.op   = cmd_cur[CMD_INT_BIT] ? OP_INT : fp_op_t'(op_code);
      assign lk.pred = cmd_cur[6:4];
      assign lane_inv[g]  = lk.invalid;
      assign lane_res[g]  = lk.result;
      assign lane_cond[g] = lk.cond;
      fpx_lane_check u_chk (
         .lk (lk.lane)
      );
   end

   // ===================================================================
   // write merge helper
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // ===================================================================
   // next state
   logic              wr_go;
   logic              exec_go;
   logic [NUM_CLASSES-1:0] ev;
   logic [NUM_CLASSES-1:0] unmasked;
   logic [31:0]       csr_w;
   logic [31:0]       rd_val;
   logic              rd_ok;

   always_comb begin
      st_nxt  = st_r;
      ev      = '0;
      csr_w   = st_r.csr;
      rd_val  = 32'h0;
      rd_ok   = 1'b1;
      exec_go = 1'b0;
      wr_go   = st_r.aw_got && st_r.w_got && !st_r.bvalid;
      st_nxt.vec_fault = 1'b0;
      st_nxt.opc_fault = 1'b0;
      // write channels taken in either order
      if (I_AWVALID && !st_r.aw_got) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.awaddr = I_AWADDR;
      end
      if (I_WVALID && !st_r.w_got) begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdata = I_WDATA;
         st_nxt.wstrb = I_WSTRB;
      end
      if (wr_go) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = AXI_OKAY;
         case (st_r.awaddr)
            ADDR_CTRL_STATUS: csr_w = merge(st_r.csr, st_r.wdata, st_r.wstrb) & CSR_WMASK;
            ADDR_OS_CTRL:     st_nxt.os_en = st_r.wdata[OS_ENABLE_BIT];
            ADDR_OP_A:        st_nxt.op_a = merge(st_r.op_a, st_r.wdata, st_r.wstrb);
            ADDR_OP_B:        st_nxt.op_b = merge(st_r.op_b, st_r.wdata, st_r.wstrb);
            ADDR_CMD: begin
               st_nxt.cmd = st_r.wdata[7:0];
               exec_go    = 1'b1;
            end
            default:          st_nxt.bresp = AXI_SLVERR;
         endcase
      end
      if (st_r.bvalid && I_BREADY) begin
         st_nxt.bvalid = 1'b0;
      end
      // ================================================================
      // instruction completion, pre then post conditions
      if (exec_go) begin
         ev[CL_INV] = |lane_inv;
         if (!(ev[CL_INV] && !st_r.csr[MASK_LSB + CL_INV])) begin
            ev[CL_OVF] = I_POST_FLAGS[0];
            ev[CL_UNF] = I_POST_FLAGS[1];
            ev[CL_PRE] = I_POST_FLAGS[2];
         end
      end
      unmasked = ev & ~st_r.csr[MASK_LSB +: NUM_CLASSES];
      csr_w[FLAG_LSB +: NUM_CLASSES] = csr_w[FLAG_LSB +: NUM_CLASSES] | ev;
      st_nxt.csr = csr_w;
      if (exec_go) begin
         if (|unmasked) begin
            st_nxt.fault = st_r.os_en ? FAULT_VECTOR : FAULT_BAD_OPCODE;
            st_nxt.vec_fault = st_r.os_en;
            st_nxt.opc_fault = !st_r.os_en;
         end else begin
            st_nxt.fault  = FAULT_NONE;
            st_nxt.result = lane_res[0];
            st_nxt.cond   = lane_cond[0];
         end
      end
      // ================================================================
      // read channel
      case (I_ARADDR)
         ADDR_CTRL_STATUS: rd_val = st_r.csr;
         ADDR_OS_CTRL:     rd_val = 32'(st_r.os_en) << OS_ENABLE_BIT;
         ADDR_OP_A:        rd_val = st_r.op_a;
         ADDR_OP_B:        rd_val = st_r.op_b;
         ADDR_CMD:         rd_val = {24'h0, st_r.cmd};
         ADDR_RESULT:      rd_val = st_r.result;
         ADDR_FAULT:       rd_val = {27'h0, st_r.cond, st_r.fault};
         ADDR_POST:        rd_val = 32'(lane_inv);
         default:          rd_ok = 1'b0;
      endcase
      if (I_ARVALID && !st_r.rvalid) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = rd_ok ? rd_val : 32'h0;
         st_nxt.rresp  = rd_ok ? AXI_OKAY : AXI_SLVERR;
      end else if (st_r.rvalid && I_RREADY) begin
         st_nxt.rvalid = 1'b0;
      end
      // readies registered from the next slot state
      st_nxt.aw_rdy = !st_nxt.aw_got;
      st_nxt.w_rdy  = !st_nxt.w_got;
      st_nxt.ar_rdy = !st_nxt.rvalid;
   end

   // ===================================================================
   // state register
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         st_r        <= '0;
         st_r.csr    <= CSR_RESET;
         st_r.aw_rdy <= 1'b1;
         st_r.w_rdy  <= 1'b1;
         st_r.ar_rdy <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign O_AWREADY          = st_r.aw_rdy;
   assign O_WREADY           = st_r.w_rdy;
   assign O_BVALID           = st_r.bvalid;
   assign O_BRESP            = st_r.bresp;
   assign O_ARREADY          = st_r.ar_rdy;
   assign O_RVALID           = st_r.rvalid;
   assign O_RDATA            = st_r.rdata;
   assign O_RRESP            = st_r.rresp;
   assign O_SIMD_FP_FAULT    = st_r.vec_fault;
   assign O_BAD_OPCODE_FAULT = st_r.opc_fault;

   // ===================================================================
   // checks
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RESET);

   chk_flag_sticky: assert property (
      st_r.csr[FLAG_LSB + CL_INV] && !(wr_go && st_r.awaddr == ADDR_CTRL_STATUS)
      |=> st_r.csr[FLAG_LSB + CL_INV]) else $error("invalid flag dropped");
   chk_inv_sets_flag: assert property (
      exec_go && |lane_inv |=> st_r.csr[FLAG_LSB + CL_INV]) else $error("invalid flag not set");
   chk_xf_on_unmask: assert property (
      exec_go && |lane_inv && !st_r.csr[MASK_LSB] && st_r.os_en
      |=> O_SIMD_FP_FAULT && !O_BAD_OPCODE_FAULT)
      else $error("vector fault missing");
   chk_ud_no_os: assert property (
      exec_go && |lane_inv && !st_r.csr[MASK_LSB] && !st_r.os_en |=> O_BAD_OPCODE_FAULT)
      else $error("bad opcode fault missing");
   chk_fault_one_shot: assert property (
      O_SIMD_FP_FAULT |=> !O_SIMD_FP_FAULT) else $error("fault held too long");
   chk_masked_result: assert property (
      exec_go && |lane_inv && st_r.csr[MASK_LSB] |=> st_r.result == $past(lane_res[0]))
      else $error("masked result not written");
   chk_unmasked_keep: assert property (
      exec_go && |lane_inv && !st_r.csr[MASK_LSB] |=> $stable(st_r.result))
      else $error("destination changed on unmasked fault");
   chk_int_no_fault: assert property (
      exec_go && cmd_cur[CMD_INT_BIT] |=> !O_SIMD_FP_FAULT && !O_BAD_OPCODE_FAULT)
      else $error("integer op faulted");
   chk_post_held: assert property (
      exec_go && |lane_inv && !st_r.csr[MASK_LSB]
      |=> st_r.csr[FLAG_LSB + CL_OVF +: 3] == $past(st_r.csr[FLAG_LSB + CL_OVF +: 3]))
      else $error("post flags set after unmasked invalid");
   chk_resp_follows: assert property (
      wr_go |=> O_BVALID) else $error("no write response");

   cov_masked_inv: cover property (exec_go && |lane_inv && st_r.csr[MASK_LSB]);
   cov_xf: cover property (O_SIMD_FP_FAULT);
   cov_ud: cover property (O_BAD_OPCODE_FAULT);
   cov_read: cover property (O_RVALID && I_RREADY);
endmodule : fpx_exception_unit

// ---- inc/fpx_pkg.sv ----
// package: register map, encodings and field positions for the vector fp exception unit
// ======================================================================
package fpx_pkg;
   // ===================================================================
   // register map (byte addresses)
   localparam logic [7:0]  ADDR_CTRL_STATUS = 8'h00;
   localparam logic [7:0]  ADDR_OS_CTRL     = 8'h04;
   localparam logic [7:0]  ADDR_OP_A        = 8'h08;
   localparam logic [7:0]  ADDR_OP_B        = 8'h0C;
   localparam logic [7:0]  ADDR_CMD         = 8'h10;
   localparam logic [7:0]  ADDR_RESULT      = 8'h14;
   localparam logic [7:0]  ADDR_FAULT       = 8'h18;
   localparam logic [7:0]  ADDR_POST        = 8'h1C;
   // ===================================================================
   // control/status fields, and the enable bit of the os control register
   // flag and mask positions
   localparam int          FLAG_LSB         = 0;
   localparam int          MASK_LSB         = 7;
   localparam int          FLUSH_ZERO_BIT   = 15;
   localparam int          OS_ENABLE_BIT    = 10;
   localparam int          NUM_CLASSES      = 6;
   localparam logic [31:0] CSR_RESET        = 32'h0000_1F80;
   localparam logic [31:0] CSR_WMASK        = 32'h0000_FFBF;
   // class index within flag or mask field
   localparam int          CL_INV           = 0;
   localparam int          CL_DEN           = 1;
   localparam int          CL_DIV           = 2;
   localparam int          CL_OVF           = 3;
   localparam int          CL_UNF           = 4;
   localparam int          CL_PRE           = 5;
   // ===================================================================
   // special values
   localparam logic [31:0] QNAN_INDEF       = 32'hFFC0_0000;
   localparam logic [31:0] INT_INDEF        = 32'h8000_0000;
   localparam logic [31:0] QUIET_BIT        = 32'h0040_0000;
   localparam logic [31:0] ALL_ONES         = 32'hFFFF_FFFF;
   localparam logic [2:0]  FLAGS_UNORD      = 3'h7;
   localparam logic [2:0]  FLAGS_GT         = 3'h0;
   localparam logic [2:0]  FLAGS_LT         = 3'h1;
   localparam logic [2:0]  FLAGS_EQ         = 3'h4;
   localparam logic [1:0]  AXI_OKAY         = 2'h0;
   localparam logic [1:0]  AXI_SLVERR       = 2'h2;
   // ===================================================================
   // operations (cmd bits 3:0), predicate in bits 6:4, integer type in bit 7
   typedef enum logic [3:0] {
      OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_SQRT, OP_MAX, OP_MIN, OP_CMP_PRED,
      OP_CMP_ORD, OP_CVT_INT, OP_CVT_PREC, OP_INT
   } fp_op_t;
   localparam logic [2:0]  PRED_UNORD       = 3'h3;
   localparam logic [2:0]  PRED_NEQ         = 3'h4;
   localparam int          CMD_INT_BIT      = 7;
   // fault codes
   localparam logic [1:0]  FAULT_NONE       = 2'h0;
   localparam logic [1:0]  FAULT_VECTOR     = 2'h1;
   localparam logic [1:0]  FAULT_BAD_OPCODE = 2'h2;
endpackage : fpx_pkg

// ---- inc/fpx_lane_if.sv ----
// interface: one element check request and its answer
interface fpx_lane_if;
   import fpx_pkg::*;
   logic [31:0] a;
   logic [31:0] b;
   fp_op_t      op;
   logic [2:0]  pred;
   logic        invalid;
   logic [31:0] result;
   logic [2:0]  cond;
   modport core (output a, b, op, pred, input invalid, result, cond);
   modport lane (input a, b, op, pred, output invalid, result, cond);
endinterface : fpx_lane_if

// ---- hdl/fpx_lane_check.sv ----
// element invalid-operation detector and masked result generator
module fpx_lane_check
   import fpx_pkg::*;
(
   fpx_lane_if.lane lk
);
   function automatic logic is_nan(input logic [31:0] v);
      return (v[30:23] == 8'hFF) && (v[22:0] != 23'h0);
   endfunction : is_nan
   function automatic logic is_snan(input logic [31:0] v);
      return is_nan(v) && !v[22];
   endfunction : is_snan
   function automatic logic is_inf(input logic [31:0] v);
      return (v[30:23] == 8'hFF) && (v[22:0] == 23'h0);
   endfunction : is_inf
   function automatic logic is_zero(input logic [31:0] v);
      return v[30:0] == 31'h0;
   endfunction : is_zero

   logic any_nan;
   logic any_snan;
   logic [31:0] quiet;
   always_comb begin
      any_nan  = is_nan(lk.a) || is_nan(lk.b);
      any_snan = is_snan(lk.a) || is_snan(lk.b);
      quiet    = (is_snan(lk.a) ? lk.a : lk.b) | QUIET_BIT;
      lk.invalid = 1'b0;
      lk.result  = lk.a;
      lk.cond    = FLAGS_GT;
      case (lk.op)
         OP_ADD, OP_SUB, OP_MUL, OP_DIV: begin
            if (any_snan) begin
               lk.invalid = 1'b1;
               lk.result  = quiet;
            end else if (any_nan) begin
               lk.result = is_nan(lk.a) ? lk.a : lk.b;
            end else if ((lk.op == OP_ADD && is_inf(lk.a) && is_inf(lk.b) && lk.a[31] != lk.b[31])
                      || (lk.op == OP_SUB && is_inf(lk.a) && is_inf(lk.b) && lk.a[31] == lk.b[31])
                      || (lk.op == OP_MUL && ((is_inf(lk.a) && is_zero(lk.b))
                                           || (is_zero(lk.a) && is_inf(lk.b))))
                      || (lk.op == OP_DIV && ((is_zero(lk.a) && is_zero(lk.b))
                                           || (is_inf(lk.a) && is_inf(lk.b))))) begin
               lk.invalid = 1'b1;
               lk.result  = QNAN_INDEF;
            end
         end
         OP_SQRT: begin
            if (is_snan(lk.a)) begin
               lk.invalid = 1'b1;
               lk.result  = lk.a | QUIET_BIT;
            end else if (!is_nan(lk.a) && lk.a[31] && !is_zero(lk.a)) begin
               lk.invalid = 1'b1;
               lk.result  = QNAN_INDEF;
            end
         end
         OP_MAX, OP_MIN: begin
            if (any_nan) begin
               lk.invalid = 1'b1;
               lk.result  = lk.b;
            end else if ((lk.op == OP_MAX) == ($signed(lk.a) > $signed(lk.b))) begin
               lk.result = lk.a;
            end else begin
               lk.result = lk.b;
            end
         end
         OP_CMP_PRED: begin
            if (any_nan) begin
               lk.invalid = 1'b1;
               lk.result  = (lk.pred == PRED_NEQ || lk.pred == PRED_UNORD) ? ALL_ONES : 32'h0;
            end else begin
               lk.result = (lk.a == lk.b) == (lk.pred != PRED_NEQ) ? ALL_ONES : 32'h0;
            end
         end
         OP_CMP_ORD: begin
            if (any_nan) begin
               lk.invalid = 1'b1;
               lk.cond    = FLAGS_UNORD;
            end else if (lk.a == lk.b) begin
               lk.cond = FLAGS_EQ;
            end else if ($signed(lk.a) < $signed(lk.b)) begin
               lk.cond = FLAGS_LT;
            end
         end
         OP_CVT_INT: begin
            if (is_nan(lk.a) || is_inf(lk.a) || lk.a[30:23] >= 8'h9E) begin
               lk.invalid = 1'b1;
               lk.result  = INT_INDEF;
            end
         end
         OP_CVT_PREC: begin
            if (is_snan(lk.a)) begin
               lk.invalid = 1'b1;
               lk.result  = lk.a | QUIET_BIT;
            end
         end
         default: begin
            lk.invalid = 1'b0;
         end
      endcase
   end
endmodule : fpx_lane_check

// ---- bench/simd_fp_invalid_exception_tb_top.sv ----
// bench: self-checking axi4-lite test of the vector fp exception unit
module simd_fp_invalid_exception_tb_top;
   import fpx_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // ===============================================
   // signals and expectation queues
   typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} exp_t;
   localparam logic [7:0] C_ADD = {4'h0, OP_ADD};
   localparam logic [7:0] C_ORD = {4'h0, OP_CMP_ORD};
   logic        clk, rst, awv, wv, bry, arv, rry, awr, wrdy, bv, arr, rv, vf, bf;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rdat;
   logic [2:0]  post;
   logic [1:0]  br, rr;
   exp_t        rq[$];
   logic [1:0]  bq[$];
   int          bad_count = 0, cmp_count = 0, nv = 0, nb = 0, seed = 91, pv;
   // masked result table
   logic [3:0]  tc[14] = '{OP_ADD, OP_SQRT, OP_SQRT, OP_MAX, OP_MIN, OP_ADD, OP_SUB, OP_MUL,
                           OP_DIV, OP_DIV, OP_CVT_INT, OP_CVT_INT, OP_CVT_INT, OP_CVT_PREC};
   logic [31:0] ta[14] = '{32'h7F800001, 32'h7F800005, 32'hBF800000, 32'h7FC00000,
                           32'h7F800001, 32'h7F800000, 32'h7F800000, 32'h7F800000, 32'h0,
                           32'h7F800000, 32'h7F800000, 32'h4F000000, 32'h7FC00000, 32'h7F800001};
   logic [31:0] tb[14] = '{32'h3F800000, 32'h0, 32'h0, 32'h12345678, 32'h3F800000,
                           32'hFF800000, 32'h7F800000, 32'h0, 32'h0, 32'h7F800000, 32'h0,
                           32'h0, 32'h0, 32'h0};
   logic [31:0] tr[14] = '{32'h7FC00001, 32'h7FC00005, QNAN_INDEF, 32'h12345678, 32'h3F800000,
                           QNAN_INDEF, QNAN_INDEF, QNAN_INDEF, QNAN_INDEF, QNAN_INDEF,
                           INT_INDEF, INT_INDEF, INT_INDEF, 32'h7FC00001};

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD %0t got %h exp %h", $time, (g), (e)); end end

   fpx_exception_unit #(.LANES(4)) dut (
      .I_CORE_CLK(clk), .I_RESET(rst),
      .I_AWVALID(awv), .I_AWADDR(awa), .O_AWREADY(awr),
      .I_WVALID(wv), .I_WDATA(wd), .I_WSTRB(4'hF), .O_WREADY(wrdy),
      .O_BVALID(bv), .O_BRESP(br), .I_BREADY(bry),
      .I_ARVALID(arv), .I_ARADDR(ara), .O_ARREADY(arr),
      .O_RVALID(rv), .O_RDATA(rdat), .O_RRESP(rr), .I_RREADY(rry),
      .I_POST_FLAGS(post), .O_SIMD_FP_FAULT(vf), .O_BAD_OPCODE_FAULT(bf));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ===============================================
   // monitor: pops the oldest note when a result appears
   always @(posedge clk) begin
      exp_t       e;
      logic [1:0] r;
      if (vf === 1'b1) nv++;
      if (bf === 1'b1) nb++;
      if (rv === 1'b1 && rry === 1'b1) begin
         e = rq.pop_front();
         `CHK(rdat & e.m, e.d & e.m)
         `CHK(rr, e.r)
      end
      if (bv === 1'b1 && bry === 1'b1) begin
         r = bq.pop_front();
         `CHK(br, r)
      end
   end
   // ===============================================
   // bus tasks
   task automatic test_done();
      $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done

   task automatic tick(inout int n);
      @(posedge clk);
      n++;
      if (n > 200) begin
         bad_count++;
         $display("BAD %0t wait expired", $time);
         test_done();
      end
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = AXI_OKAY);
      bit ad, dd;
      int n;
      ad = 0;
      dd = 0;
      n = 0;
      @(posedge clk);
      bq.push_back(r);
      awv <= 1'b1;
      awa <= a;
      wv  <= 1'b1;
      wd  <= d;
      bry <= 1'b1;
      forever begin
         tick(n);
         if (ad && dd && bv === 1'b1) break;
         if (awr === 1'b1) begin
            ad = 1;
            awv <= 1'b0;
         end
         if (wrdy === 1'b1) begin
            dd = 1;
            wv <= 1'b0;
         end
      end
      bry <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m = ALL_ONES, input logic [1:0] r = AXI_OKAY);
      bit ad;
      int n;
      ad = 0;
      n = 0;
      @(posedge clk);
      rq.push_back('{d, m, r});
      arv <= 1'b1;
      ara <= a;
      rry <= 1'b1;
      forever begin
         tick(n);
         if (ad && rv === 1'b1) break;
         if (arr === 1'b1) begin
            ad = 1;
            arv <= 1'b0;
         end
      end
      rry <= 1'b0;
   endtask : rd

   task automatic ex(input logic [7:0] c, input int ev, input int eb);
      int v0, b0;
      v0 = nv;
      b0 = nb;
      wr(ADDR_CMD, {24'h0, c});
      repeat (2) @(posedge clk);
      `CHK(nv - v0, ev)
      `CHK(nb - b0, eb)
   endtask : ex

   task automatic op(input logic [31:0] a, input logic [31:0] b, input logic [7:0] c,
                     input int ev = 0, input int eb = 0);
      wr(ADDR_OP_A, a);
      wr(ADDR_OP_B, b);
      ex(c, ev, eb);
   endtask : op
   // ===============================================
   // main sequence
   initial begin
      rst = 1'b1;
      {awv, wv, bry, arv, rry} = 5'h0;
      awa = 8'h0;
      ara = 8'h0;
      wd = 32'h0;
      post = 3'h0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_CTRL_STATUS, CSR_RESET);
      rd(ADDR_OS_CTRL, 32'h0);
      rd(8'h20, 32'h0, ALL_ONES, AXI_SLVERR);
      wr(8'h20, 32'h0, AXI_SLVERR);
      wr(ADDR_CTRL_STATUS, ALL_ONES);
      rd(ADDR_CTRL_STATUS, CSR_WMASK);
      for (int i = 0; i < 14; i++) begin
         wr(ADDR_CTRL_STATUS, CSR_RESET);
         op(ta[i], tb[i], {4'h0, tc[i]});
         rd(ADDR_RESULT, tr[i]);
         rd(ADDR_CTRL_STATUS, 32'h1, 32'h1);
      end
      for (int p = 0; p < 8; p++) begin
         op(32'h7FC00000, 32'h3F800000, {1'b0, p[2:0], OP_CMP_PRED});
         rd(ADDR_RESULT, (p == PRED_UNORD || p == PRED_NEQ) ? ALL_ONES : 32'h0);
      end
      op(32'h7FC00000, 32'h3F800000, C_ORD);
      rd(ADDR_FAULT, {27'h0, FLAGS_UNORD, FAULT_NONE}, 32'h1F);
      wr(ADDR_CTRL_STATUS, CSR_RESET);
      op(32'h7F800001, 32'h3F800000, C_ADD);
      op(32'h3F800000, 32'h3F800000, C_ADD);
      rd(ADDR_CTRL_STATUS, 32'h1, 32'h1);
      wr(ADDR_CTRL_STATUS, CSR_RESET);
      op(32'h7F7FFFFF, 32'hFF800000, C_ADD);
      rd(ADDR_POST, 32'hE, 32'hF);
      repeat (4) begin
         wr(ADDR_CTRL_STATUS, CSR_RESET);
         pv = $random(seed);
         post <= pv[2:0];
         op(32'h3F800000, 32'h3F800000, C_ADD);
         rd(ADDR_CTRL_STATUS, CSR_RESET | {26'h0, pv[2:0], 3'h0});
      end
      post <= 3'h7;
      wr(ADDR_CTRL_STATUS, 32'h1F00);
      op(32'h7F800001, 32'h3F800000, C_ADD, 0, 1);
      rd(ADDR_FAULT, {30'h0, FAULT_BAD_OPCODE}, 32'h3);
      rd(ADDR_CTRL_STATUS, 32'h1F01);
      rd(ADDR_OP_A, 32'h7F800001);
      rd(ADDR_OP_B, 32'h3F800000);
      post <= 3'h0;
      wr(ADDR_OS_CTRL, 32'h400);
      ex(C_ADD, 1, 0);
      rd(ADDR_FAULT, {30'h0, FAULT_VECTOR}, 32'h3);
      op(32'h7FC00000, 32'h3F800000, C_ADD);
      ex(C_ORD, 1, 0);
      wr(ADDR_CTRL_STATUS, 32'h9F00);
      op(32'h7F800001, 32'h3F800000, C_ADD, 1, 0);
      wr(ADDR_CTRL_STATUS, 32'h1F00);
      ex({1'b1, 3'h0, OP_ADD}, 0, 0);
      rd(ADDR_CTRL_STATUS, 32'h1F00);
      test_done();
   end
endmodule : simd_fp_invalid_exception_tb_top
